// File: hdl/slr_pkg.sv
// Constants, types and helpers for the socket legacy control registers.
// Assumes an APB master on pclk; card, device and diagnostic registers sit in the low byte of a word, identification uses all 32 bits.
package slr_pkg;

  // Printed register indices; byte address is four times the index
  localparam logic [9:0]  IDX_ID     = 10'h000;
  localparam logic [9:0]  IDX_CARD   = 10'h091;
  localparam logic [9:0]  IDX_DEVICE = 10'h092;
  localparam logic [9:0]  IDX_DIAG   = 10'h093;
  localparam int          ADDR_W     = 12;

  // Reset values
  localparam logic [7:0]  RST_CARD   = 8'h00;
  localparam logic [7:0]  RST_DEVICE = 8'h66;
  localparam logic [7:0]  RST_DIAG   = 8'h61;

  // Plain storage bits that a write may change; flag bit is handled apart
  localparam logic [7:0]  WR_CARD    = 8'he6;
  localparam logic [7:0]  WR_DEVICE  = 8'h6f;
  localparam logic [7:0]  WR_DIAG    = 8'hff;

  // Card control fields
  localparam int CC_RING    = 7;
  localparam int CC_ZOOM    = 6;
  localparam int CC_SPARE   = 5;
  localparam int CC_AUDIO   = 2;
  localparam int CC_SPEAKER = 1;
  localparam int CC_FLAG    = 0;
  // Device control fields
  localparam int DC_LOWV  = 6;
  localparam int DC_DIAG  = 5;
  localparam int DC_TEST  = 3;
  localparam int DC_MODE  = 1;
  localparam int DC_RSVD0 = 0;
  // Diagnostic fields
  localparam int DG_MASK  = 7;
  localparam int DG_ASYNC = 0;

  localparam int SYNC_W   = 4;

  typedef enum logic [1:0] {
    MODE_PAR_PCI,
    MODE_PAR_IRQ_PAR_PCI,
    MODE_SER_IRQ_PAR_PCI,
    MODE_SER_IRQ_SER_PCI
  } slr_mode_type;

  typedef struct packed {
    logic serial_irq;
    logic parallel_irq;
    logic serial_pci;
    logic parallel_pci;
  } slr_route_type;

  function automatic slr_route_type slr_mode_decode(input logic [1:0] m);
    slr_route_type r;
    r = '0;
    case (slr_mode_type'(m))
      MODE_PAR_PCI:         r.parallel_pci = 1'b1;
      MODE_PAR_IRQ_PAR_PCI: r = '{1'b0, 1'b1, 1'b0, 1'b1};
      MODE_SER_IRQ_PAR_PCI: r = '{1'b1, 1'b0, 1'b0, 1'b1};
      MODE_SER_IRQ_SER_PCI: r = '{1'b1, 1'b0, 1'b1, 1'b0};
      default:              r = '0;
    endcase
    return r;
  endfunction

endpackage

// File: hdl/slr_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous levels; first stage feeds only the second.
`timescale 1ns/1ps
module slr_sync
  import slr_pkg::*;
#(
  parameter int WIDTH = SYNC_W
) (
  input  wire logic             clk,     // Register clock
  input  wire logic             rst_n,   // Async reset, active low
  input  wire logic             ce,      // Clock enable
  input  wire logic [WIDTH-1:0] din,     // Asynchronous levels
  output logic      [WIDTH-1:0] dout     // Synchronised levels
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // slr_sync

// File: hdl/slr_flag.sv
// Sticky event flag with write-one-to-clear.
// Assumes set and clear are single-clock-domain levels.
`timescale 1ns/1ps
module slr_flag (
  input  wire logic clk,     // Register clock
  input  wire logic rst_n,   // Async reset, active low
  input  wire logic ce,      // Clock enable
  input  wire logic set,     // Event level
  input  wire logic clr,     // Clear strobe
  output logic      q        // Sticky flag
);
  wire next_q = set | (q & ~clr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (ce) begin
      q <= next_q;
    end
  end
endmodule // slr_flag

// File: hdl/slr_regs.sv
// Socket legacy control registers: card, device and diagnostic bytes on APB.
// Assumes an APB master on pclk; card pins arrive asynchronously,
// ring indicate comes from logic on pclk.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Card bit 7 gates ring indicate; routes to ring pin or multifunction pin.
// - Card bit 6 set floats the zoom video terminals.
// - Card bit 2 forwards card audio PWM to internal audio PWM signal.
// - Speaker output carries card speaker data only while card bit 1 set.
// - Card bit 0 sets on card functional interrupt; write one clears.
// - Card bit 5 plain storage; bits 4 and 3 read zero.
// - Device bits 7 and 4 read zero; writes ignored.
// - Device bit 6 forces low voltage capability; resets to one.
// - Device bit 3 shortens interrogation counter; software writes zero.
// - Device bits 2-1 select interrupt signalling mode; reset 11.
// - Diagnostic bit 0 lets status change interrupts skip clock wait.
// - Diagnostic bit 7 makes identification reads return all ones.
module slr_regs
  import slr_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID = 16'h1234,  // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5678   // Arbitrary value
) (
  input  wire logic              pclk,                // Bus clock
  input  wire logic              presetn,             // Async reset, low
  input  wire logic              pce,                 // Clock enable
  input  wire logic              psel,                // APB select
  input  wire logic              penable,             // APB enable
  input  wire logic              pwrite,              // APB write
  input  wire logic [ADDR_W-1:0] paddr,               // APB byte address
  input  wire logic [31:0]       pwdata,              // APB write data
  output logic      [31:0]       prdata,              // APB read data
  output logic                   pready,              // APB ready
  output logic                   pslverr,             // APB error
  input  wire logic              ring_indicate_in,    // Ring indicate source
  input  wire logic              ring_pin_select,     // 0: ring pin
  input  wire logic              card_audio_in,       // Card audio PWM pin
  input  wire logic              card_speaker,        // Card speaker pin
  input  wire logic              card_func_irq,       // Card interrupt pin
  input  wire logic              card_status_change,  // Status change pin
  output logic                   ring_indicate_out,   // To ring pin
  output logic                   ring_mfunc_out,      // To multifunction pin
  output logic                   zoom_video_oe_n,     // Low drives zoom pins
  output logic                   audio_pwm_signal,    // To pin selectors
  output logic                   speaker_out_pin,     // Speaker data
  output logic                   speaker_out_oe_n,    // Low drives speaker
  output logic                   card_irq_flag,       // Sticky card flag
  output logic                   low_volt_capable,    // Report 3 V capable
  output logic                   interrogation_short, // Short counter
  output slr_route_type          irq_route,           // Signalling paths
  output logic                   diag_io_bit,         // Device diag bit
  output logic [7:0]             diagnostic_control,  // Diagnostic byte
  output logic                   status_change_irq    // Status change irq
);

////////////////////////////////////////////////////////////////////////////////
// Register storage

  logic [7:0] card_control;
  logic [7:0] device_control;
  logic       flag_q;
  logic [SYNC_W-1:0] pins_s;
  logic       change_late;

  wire audio_s   = pins_s[0];
  wire speaker_s = pins_s[1];
  wire irq_s     = pins_s[2];
  wire change_s  = pins_s[3];

////////////////////////////////////////////////////////////////////////////////
// APB decode

  wire [9:0] word_idx  = paddr[ADDR_W-1:2];
  wire       hit_id    = (word_idx == IDX_ID);
  wire       hit_card  = (word_idx == IDX_CARD);
  wire       hit_dev   = (word_idx == IDX_DEVICE);
  wire       hit_diag  = (word_idx == IDX_DIAG);
  wire       hit_any   = hit_id | hit_card | hit_dev | hit_diag;
  wire       setup_ph  = psel & ~penable & ~pready;
  wire       commit    = psel & penable & pready;
  wire       wr_ok     = commit & pwrite & hit_any;
  wire       wr_card   = wr_ok & hit_card;
  wire       wr_dev    = wr_ok & hit_dev;
  wire       wr_diag   = wr_ok & hit_diag;
  wire [7:0] wbyte     = pwdata[7:0];

  wire       flag_clr  = wr_card & wbyte[CC_FLAG];

  wire [7:0] card_rd   = (card_control & WR_CARD) | {7'h00, flag_q};
  wire [7:0] dev_rd    = device_control & WR_DEVICE;
  wire [31:0] id_rd    = diagnostic_control[DG_MASK] ? 32'hffff_ffff
                                                      : {DEVICE_ID, VENDOR_ID};

  wire [31:0] rd_mux   = hit_id   ? id_rd :
                         hit_card ? {24'h000000, card_rd} :
                         hit_dev  ? {24'h000000, dev_rd} :
                         hit_diag ? {24'h000000, diagnostic_control} :
                                    32'h0000_0000;

  wire [7:0] next_card = (card_control & ~WR_CARD) | (wbyte & WR_CARD);
  wire [7:0] next_dev  = (device_control & ~WR_DEVICE) | (wbyte & WR_DEVICE);
  wire [7:0] next_diag = (diagnostic_control & ~WR_DIAG) | (wbyte & WR_DIAG);

////////////////////////////////////////////////////////////////////////////////
// APB answer: no wait state; read data comes from a flop loaded in the setup phase

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (pce) begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit_any;
      if (setup_ph) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Register writes

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_control       <= RST_CARD;
      device_control     <= RST_DEVICE;
      diagnostic_control <= RST_DIAG;
    end else if (pce) begin
      if (wr_card) begin
        card_control <= next_card;
      end
      if (wr_dev) begin
        device_control <= next_dev;
      end
      if (wr_diag) begin
        diagnostic_control <= next_diag;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and the sticky flag

  slr_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (pce),
    .din   ({card_status_change, card_func_irq, card_speaker, card_audio_in}),
    .dout  (pins_s)
  );

  slr_flag u_flag (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (pce),
    .set   (irq_s),
    .clr   (flag_clr),
    .q     (flag_q)
  );

////////////////////////////////////////////////////////////////////////////////
// Socket-facing outputs

  wire ring_en = card_control[CC_RING];
  wire spk_en  = card_control[CC_SPEAKER];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_indicate_out   <= 1'b0;
      ring_mfunc_out      <= 1'b0;
      zoom_video_oe_n     <= 1'b0;
      audio_pwm_signal    <= 1'b0;
      speaker_out_pin     <= 1'b0;
      speaker_out_oe_n    <= 1'b1;
      card_irq_flag       <= 1'b0;
      low_volt_capable    <= RST_DEVICE[DC_LOWV];
      interrogation_short <= RST_DEVICE[DC_TEST];
      irq_route           <= slr_mode_decode(RST_DEVICE[DC_MODE +: 2]);
      diag_io_bit         <= RST_DEVICE[DC_DIAG];
      change_late         <= 1'b0;
      status_change_irq   <= 1'b0;
    end else if (pce) begin
      ring_indicate_out   <= ring_en & ~ring_pin_select & ring_indicate_in;
      ring_mfunc_out      <= ring_en & ring_pin_select & ring_indicate_in;
      zoom_video_oe_n     <= card_control[CC_ZOOM];
      audio_pwm_signal    <= card_control[CC_AUDIO] & audio_s;
      speaker_out_pin     <= spk_en & speaker_s;
      speaker_out_oe_n    <= ~spk_en;
      card_irq_flag       <= flag_q;
      low_volt_capable    <= device_control[DC_LOWV];
      interrogation_short <= device_control[DC_TEST];
      irq_route           <= slr_mode_decode(device_control[DC_MODE +: 2]);
      diag_io_bit         <= device_control[DC_DIAG];
      change_late         <= change_s;
      status_change_irq   <= diagnostic_control[DG_ASYNC] ? change_s : change_late;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Assertions

  property p_ring_off;
    @(posedge pclk) disable iff (!presetn)
      (pce && !ring_en) |=> !ring_indicate_out && !ring_mfunc_out;
  endproperty
  a_ring_off: assert property (p_ring_off)
    else $error("ring output active while disabled");

  property p_ring_pin;
    @(posedge pclk) disable iff (!presetn)
      (pce && ring_en && !ring_pin_select && ring_indicate_in)
        |=> ring_indicate_out && !ring_mfunc_out;
  endproperty
  a_ring_pin: assert property (p_ring_pin)
    else $error("ring not routed to ring pin");

  property p_zoom;
    @(posedge pclk) disable iff (!presetn)
      pce && wr_card ##1 pce |=> zoom_video_oe_n == $past(wbyte[CC_ZOOM], 2);
  endproperty
  a_zoom: assert property (p_zoom)
    else $error("zoom float does not follow write");

  property p_audio;
    @(posedge pclk) disable iff (!presetn)
      (pce && !card_control[CC_AUDIO]) |=> !audio_pwm_signal;
  endproperty
  a_audio: assert property (p_audio)
    else $error("audio forwarded while off");

  property p_speaker;
    @(posedge pclk) disable iff (!presetn)
      (pce && !spk_en) |=> !speaker_out_pin && speaker_out_oe_n;
  endproperty
  a_speaker: assert property (p_speaker)
    else $error("speaker driven while disabled");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      (pce && irq_s) |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("interrupt lost");

  property p_flag_keep;
    @(posedge pclk) disable iff (!presetn)
      (pce && flag_q && wr_card && !wbyte[CC_FLAG]) |=> flag_q;
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("flag cleared by zero write");

  property p_flag_clr;
    @(posedge pclk) disable iff (!presetn)
      (pce && flag_clr && !irq_s) |=> !flag_q;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("flag not cleared");

  property p_card_rsvd;
    @(posedge pclk) disable iff (!presetn)
      pready && hit_card && !pwrite |-> prdata[4:3] == 2'b00;
  endproperty
  a_card_rsvd: assert property (p_card_rsvd)
    else $error("card reserved bits nonzero");

  property p_dev_rsvd;
    @(posedge pclk) disable iff (!presetn)
      pready && hit_dev && !pwrite |-> !prdata[7] && !prdata[4];
  endproperty
  a_dev_rsvd: assert property (p_dev_rsvd)
    else $error("device reserved bits nonzero");

  property p_mode;
    @(posedge pclk) disable iff (!presetn)
      pce |=> irq_route == slr_mode_decode($past(device_control[DC_MODE +: 2]));
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode decode wrong");

  property p_test;
    @(posedge pclk) disable iff (!presetn)
      pce && wr_dev ##1 pce |=> interrogation_short == $past(wbyte[DC_TEST], 2);
  endproperty
  a_test: assert property (p_test)
    else $error("test bit not applied");

  property p_lowv;
    @(posedge pclk) disable iff (!presetn)
      pce && wr_dev ##1 pce |=> low_volt_capable == $past(wbyte[DC_LOWV], 2);
  endproperty
  a_lowv: assert property (p_lowv)
    else $error("capability bit not applied");

  property p_async;
    @(posedge pclk) disable iff (!presetn)
      (pce && diagnostic_control[DG_ASYNC]) |=> status_change_irq == $past(change_s);
  endproperty
  a_async: assert property (p_async)
    else $error("status change not fast");

  property p_idmask;
    @(posedge pclk) disable iff (!presetn)
      (pce && setup_ph && hit_id && !pwrite && diagnostic_control[DG_MASK])
        |=> prdata == 32'hffff_ffff;
  endproperty
  a_idmask: assert property (p_idmask)
    else $error("identification not masked");

  property p_ring_mux;
    @(posedge pclk) disable iff (!presetn)
      (pce && ring_en && ring_pin_select && ring_indicate_in)
        |=> ring_mfunc_out && !ring_indicate_out;
  endproperty
  a_ring_mux: assert property (p_ring_mux)
    else $error("ring not routed to multifunction pin");

  property p_card_store;
    @(posedge pclk) disable iff (!presetn)
      (pce && wr_card) |=> card_control[CC_SPARE] == $past(wbyte[CC_SPARE]);
  endproperty
  a_card_store: assert property (p_card_store)
    else $error("card storage bit not written");

  property p_diag_hold;
    @(posedge pclk) disable iff (!presetn)
      (!pce || !wr_diag) |=> $stable(diagnostic_control);
  endproperty
  a_diag_hold: assert property (p_diag_hold)
    else $error("diagnostic byte changed without a write");

endmodule // slr_regs

// File: tb/slr_regs_test.sv
// Self-checking bench for the socket legacy control registers.
// Assumes slr_pkg and slr_regs are compiled first; the bench is the APB master.
`timescale 1ns/1ps
module slr_regs_test;
  import slr_pkg::*;

  // Identification values handed to the design; arbitrary
  localparam logic [15:0]       VID    = 16'h1234;
  localparam logic [15:0]       DID    = 16'h5678;
  localparam logic [ADDR_W-1:0] A_ID   = {IDX_ID, 2'b00};
  localparam logic [ADDR_W-1:0] A_CARD = {IDX_CARD, 2'b00};
  localparam logic [ADDR_W-1:0] A_DEV  = {IDX_DEVICE, 2'b00};
  localparam logic [ADDR_W-1:0] A_DIAG = {IDX_DIAG, 2'b00};
  localparam logic [ADDR_W-1:0] A_BAD  = 12'h250;
  localparam logic [3:0]        ROUTES [4] = '{4'h1, 4'h5, 4'h9, 4'ha};

  logic              pclk, presetn, pce, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdat;
  logic              pready, pslverr, rerr;
  logic              ring_indicate_in, ring_pin_select, card_audio_in, card_speaker;
  logic              card_func_irq, card_status_change;
  logic              ring_indicate_out, ring_mfunc_out, zoom_video_oe_n, audio_pwm_signal;
  logic              speaker_out_pin, speaker_out_oe_n, card_irq_flag, low_volt_capable;
  logic              interrogation_short, diag_io_bit, status_change_irq;
  slr_route_type     irq_route;
  logic [7:0]        diagnostic_control;
  int                n_errors, n_compared;

  slr_regs #(.VENDOR_ID(VID), .DEVICE_ID(DID)) i_dut (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ring_indicate_in(ring_indicate_in),
    .ring_pin_select(ring_pin_select), .card_audio_in(card_audio_in),
    .card_speaker(card_speaker), .card_func_irq(card_func_irq),
    .card_status_change(card_status_change), .ring_indicate_out(ring_indicate_out),
    .ring_mfunc_out(ring_mfunc_out), .zoom_video_oe_n(zoom_video_oe_n),
    .audio_pwm_signal(audio_pwm_signal), .speaker_out_pin(speaker_out_pin),
    .speaker_out_oe_n(speaker_out_oe_n), .card_irq_flag(card_irq_flag),
    .low_volt_capable(low_volt_capable), .interrogation_short(interrogation_short),
    .irq_route(irq_route), .diag_io_bit(diag_io_bit),
    .diagnostic_control(diagnostic_control), .status_change_irq(status_change_irq)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                          input logic [31:0] wd, output logic [31:0] rd,
                          output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] addr, input logic [7:0] d);
    apb_xfer(1'b1, addr, {24'h0, d}, rdat, rerr);
    check(rerr, 1'b0);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] addr, input logic [31:0] exp);
    apb_xfer(1'b0, addr, 32'h0, rdat, rerr);
    check(rdat, exp);
    check(rerr, 1'b0);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // Status change latency, three edges with the skip bit set, else four
  task automatic change_case(input logic async, input int edges);
    wr(A_DIAG, {7'h0, async});
    @(posedge pclk);
    card_status_change <= 1'b1;
    settle(edges - 1);
    check(status_change_irq, 1'b0);
    settle(1);
    check(status_change_irq, 1'b1);
    @(posedge pclk);
    card_status_change <= 1'b0;
    settle(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    {presetn, psel, penable, pwrite, ring_indicate_in, ring_pin_select} = '0;
    {card_audio_in, card_speaker, card_func_irq, card_status_change} = '0;
    paddr = '0;
    pwdata = '0;
    pce = 1'b1;
    n_errors = 0;
    n_compared = 0;
    repeat (16) @(posedge pclk);
    check(irq_route, 4'ha);
    check({low_volt_capable, speaker_out_oe_n, zoom_video_oe_n}, 3'b110);
    check(diagnostic_control, RST_DIAG);
    presetn <= 1'b1;
    rd(A_CARD, 32'h00);
    rd(A_DEV, 32'h66);
    rd(A_DIAG, 32'h61);
    // Card byte: routing, float, audio and speaker paths
    ring_indicate_in <= 1'b1;
    card_audio_in <= 1'b1;
    card_speaker <= 1'b1;
    wr(A_CARD, 8'hff);
    rd(A_CARD, 32'he6);
    settle(5);
    check({ring_indicate_out, ring_mfunc_out}, 2'b10);
    check(zoom_video_oe_n, 1'b1);
    check(audio_pwm_signal, 1'b1);
    check({speaker_out_pin, speaker_out_oe_n}, 2'b10);
    ring_pin_select <= 1'b1;
    card_audio_in <= 1'b0;
    card_speaker <= 1'b0;
    settle(5);
    check({ring_indicate_out, ring_mfunc_out}, 2'b01);
    check(audio_pwm_signal, 1'b0);
    check({speaker_out_pin, speaker_out_oe_n}, 2'b00);
    card_audio_in <= 1'b1;
    wr(A_CARD, 8'h00);
    settle(5);
    check({ring_indicate_out, ring_mfunc_out}, 2'b00);
    check(zoom_video_oe_n, 1'b0);
    check(audio_pwm_signal, 1'b0);
    check(speaker_out_oe_n, 1'b1);
    // Sticky flag: zero write keeps it, set wins over clear
    card_func_irq <= 1'b1;
    settle(2);
    card_func_irq <= 1'b0;
    settle(4);
    rd(A_CARD, 32'h01);
    check(card_irq_flag, 1'b1);
    wr(A_CARD, 8'h00);
    rd(A_CARD, 32'h01);
    card_func_irq <= 1'b1;
    settle(4);
    wr(A_CARD, 8'h01);
    rd(A_CARD, 32'h01);
    card_func_irq <= 1'b0;
    settle(4);
    wr(A_CARD, 8'h01);
    rd(A_CARD, 32'h00);
    settle(2);
    check(card_irq_flag, 1'b0);
    // Clock enable low: a pin event in that span is never seen
    pce <= 1'b0;
    card_func_irq <= 1'b1;
    repeat (6) @(posedge pclk);
    card_func_irq <= 1'b0;
    pce <= 1'b1;
    repeat (4) @(posedge pclk);
    check(card_irq_flag, 1'b0);
    rd(A_CARD, 32'h00);
    // Device byte and every signalling mode
    wr(A_DEV, 8'hfe);
    rd(A_DEV, 32'h6e);
    settle(2);
    check({low_volt_capable, interrogation_short, diag_io_bit}, 3'b111);
    for (int m = 0; m < 4; m++) begin
      wr(A_DEV, {5'h0, m[1:0], 1'b0});
      rd(A_DEV, {29'h0, m[1:0], 1'b0});
      settle(2);
      check(irq_route, ROUTES[m]);
    end
    check({low_volt_capable, interrogation_short}, 2'b00);
    // Identification masking
    wr(A_DIAG, 8'h80);
    rd(A_ID, 32'hffffffff);
    settle(2);
    check(diagnostic_control, 8'h80);
    wr(A_DIAG, 8'h5e);
    rd(A_ID, {DID, VID});
    rd(A_DIAG, 32'h5e);
    change_case(1'b1, 3);
    change_case(1'b0, 4);
    // Unmapped place: error, no data, no side effect
    apb_xfer(1'b1, A_BAD, 32'hff, rdat, rerr);
    check(rerr, 1'b1);
    apb_xfer(1'b0, A_BAD, 32'h0, rdat, rerr);
    check(rerr, 1'b1);
    check(rdat, 32'h0);
    rd(A_DIAG, 32'h00);
    // Second reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_DEV, 32'h66);
    rd(A_DIAG, 32'h61);
    check({low_volt_capable, speaker_out_oe_n}, 2'b11);
    summarize();
  end
endmodule // slr_regs_test
